// ### hw/pin_sync.v
// Three-stage pin synchroniser with agreement filter.
// Assumes one system clock; input is asynchronous.
`timescale 1ns/1ps
module pin_sync (
    input wire clock,
    input wire rst_n,
    input wire pin,
    input wire reset_value,
    output reg level
);
    reg s1;
    reg s2;
    reg s3;

    // ------------------------------------------------------------
    // Capture chain
    // ------------------------------------------------------------
    // First stage feeds only the second, to keep metastability contained
    // Reset loads the pin's idle level, so no false edge follows reset
    always @(posedge clock) begin
        if (!rst_n) begin
            s1 <= reset_value;
            s2 <= reset_value;
            s3 <= reset_value;
            level <= reset_value;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3; // Change counts once stages two and three agree
            end
        end
    end
endmodule // pin_sync

// ### hw/sar_adc_control.v
// Digital control of a 12-bit serial successive-approximation converter.
// Assumes host drives select_n and serial_bit_clock as pins, sampled on clock;
// comparator is an input from the analog section, valid one period after trial.
`timescale 1ns/1ps
`include "sar_adc_regs.vh"

// What this block does
// - The result is straight binary, from all zeros at zero input up to FFF at full scale.
// - The analog part powers down when a conversion has finished, and the whole converter whenever select is high.
// - After a finished conversion with select low only the analog part sleeps; full shutdown needs select high.
// - The host may end a conversion early by raising select, and each bit is output as soon as decided.
// - Each serial clock period of the MSB pass makes one bit decision and outputs that same bit.
// - After the null bit the 12 bits go out MSB first, then bits 1 to 11 LSB first, then the output floats.
// - Bits launch on the falling serial clock edge and the host samples on the rising edge.
module sar_adc_control #(
    parameter BITS = `RESULT_BITS
) (
    input wire clock,
    input wire rst_n,
    input wire select_n,
    input wire serial_bit_clock,
    input wire comparator,
    output reg data_out,
    output reg data_out_en,
    output reg [BITS-1:0] trial_code,
    output reg sample_en,
    output reg analog_on,
    output reg digital_on,
    output reg [BITS-1:0] result,
    output reg result_valid
);
    // ------------------------------------------------------------
    // Frame phases
    // ------------------------------------------------------------
    // Binary coded; idle is also the phase taken at reset
    localparam [2:0] PHASE_IDLE = 3'h0;
    localparam [2:0] PHASE_SAMPLE = 3'h1;
    localparam [2:0] PHASE_NULL = 3'h2;
    localparam [2:0] PHASE_MSB = 3'h3;
    localparam [2:0] PHASE_LSB = 3'h4;
    localparam [2:0] PHASE_DONE = 3'h5;

    // ------------------------------------------------------------
    // Internal state
    // ------------------------------------------------------------
    // Synchronised pin levels and their copies one clock older
    wire sel_n;
    wire sclk;
    reg sclk_d;
    reg sel_d;
    // Frame progress: phase, clock falls while sampling, bit under work
    reg [2:0] phase;
    reg [3:0] falls;
    reg [3:0] index;
    // Bits decided so far; the bit under trial is not valid here yet
    reg [BITS-1:0] code;
    // Set while select is seen high, so a start needs a fresh select fall
    reg armed;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    pin_sync u_sel (
        .clock(clock),
        .rst_n(rst_n),
        .pin(select_n),
        .reset_value(`SELECT_IDLE),
        .level(sel_n)
    );
    pin_sync u_sclk (
        .clock(clock),
        .rst_n(rst_n),
        .pin(serial_bit_clock),
        .reset_value(`SCLK_IDLE),
        .level(sclk)
    );

    wire sclk_fall = sclk_d & ~sclk;
    wire sel_fall = sel_d & ~sel_n;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Bit at position i of the code, used for the LSB pass
    function pick;
        input [BITS-1:0] value;
        input [3:0] pos;
        begin
            pick = value[pos];
        end
    endfunction

    // One-hot mask for one bit position of the trial code
    function [BITS-1:0] bit_mask;
        input [3:0] pos;
        begin
            bit_mask = {{(BITS-1){1'b0}}, 1'b1} << pos;
        end
    endfunction

    // Keep the decision at pos and put the next lower bit on trial.
    // Only valid for pos above zero; the last decision ends the MSB pass.
    function [BITS-1:0] next_trial;
        input [BITS-1:0] trial;
        input [3:0] pos;
        input decision;
        begin
            next_trial = (trial & ~bit_mask(pos))
                | ({{(BITS-1){1'b0}}, decision} << pos)
                | bit_mask(pos - 4'h1);
        end
    endfunction

    // Final code: the decided upper bits joined with the last decision
    function [BITS-1:0] final_code;
        input [BITS-1:0] decided;
        input last;
        begin
            final_code = {decided[BITS-1:1], last};
        end
    endfunction

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    // Select acts as both reset and start; the edge copies reset to the
    // idle pin levels, so reset alone never looks like a select fall.
    always @(posedge clock) begin
        if (!rst_n) begin
            sclk_d <= `SCLK_IDLE;
            sel_d <= `SELECT_IDLE;
            phase <= PHASE_IDLE;
            falls <= 4'h0;
            index <= 4'h0;
            code <= {BITS{1'b0}};
            trial_code <= {BITS{1'b0}};
            armed <= 1'b0;
            data_out <= 1'b0;
            data_out_en <= 1'b0;
            sample_en <= 1'b0;
            analog_on <= 1'b0;
            digital_on <= 1'b0;
            result <= {BITS{1'b0}};
            result_valid <= 1'b0;
        end else begin
            sclk_d <= sclk;
            sel_d <= sel_n;
            result_valid <= 1'b0;
            if (sel_n) begin
                // Abandon any frame and shut everything down
                phase <= PHASE_IDLE;
                data_out_en <= 1'b0;
                data_out <= 1'b0;
                sample_en <= 1'b0;
                analog_on <= 1'b0;
                digital_on <= 1'b0; // Full shutdown only while select high
                armed <= 1'b1; // Select seen high; next fall may start
            end else if (sel_fall && armed) begin
                // Start: sample until the second clock fall
                phase <= PHASE_SAMPLE;
                falls <= 4'h0;
                armed <= 1'b0;
                sample_en <= 1'b1;
                analog_on <= 1'b1;
                digital_on <= 1'b1;
                code <= {BITS{1'b0}};
                trial_code <= {1'b1, {(BITS-1){1'b0}}};
            end else if (sclk_fall) begin
                // Between start and abort, outputs change on the falling clock edge; result_valid clears a clock later
                case (phase)
                    PHASE_SAMPLE: begin
                        falls <= falls + 4'h1;
                        if (falls + 4'h1 == `FALL_NULL) begin
                            // Output enabled with a low null bit
                            sample_en <= 1'b0;
                            data_out_en <= 1'b1;
                            data_out <= 1'b0;
                            phase <= PHASE_NULL;
                            index <= BITS[3:0] - 4'h1;
                        end
                    end
                    PHASE_NULL, PHASE_MSB: begin
                        // Decide current bit and drive it out at once
                        code[index] <= comparator;
                        data_out <= comparator; // MSB first pass
                        if (index == 4'h0) begin
                            // Straight binary code, no offset or sign change
                            result <= final_code(code, comparator);
                            result_valid <= 1'b1;
                            trial_code <= final_code(code, comparator);
                            analog_on <= 1'b0; // Analog sleeps, digital keeps running
                            phase <= PHASE_LSB;
                            index <= 4'h1;
                        end else begin
                            trial_code <= next_trial(trial_code, index, comparator);
                            index <= index - 4'h1;
                            phase <= PHASE_MSB;
                        end
                    end
                    PHASE_LSB: begin
                        // Repeat result LSB first, ending with the top bit
                        if (index == BITS[3:0]) begin
                            data_out_en <= 1'b0;
                            data_out <= 1'b0;
                            phase <= PHASE_DONE;
                        end else begin
                            data_out <= pick(result, index);
                            index <= index + 4'h1;
                        end
                    end
                    PHASE_DONE: begin
                        // Further clocks have no effect until select cycles
                        phase <= PHASE_DONE;
                    end
                    default: begin
                        phase <= PHASE_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // sar_adc_control

// ### hw/sar_adc_regs.vh
// Constants for the serial successive-approximation converter control block.
// Assumes inclusion by bare name; definitions only.
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH

// ------------------------------------------------------------
// Frame layout, in serial clock falling edges
// ------------------------------------------------------------
`define RESULT_BITS 12
`define FALL_NULL 4'h2
// Reset levels of the synchronised pins, equal to their idle levels
`define SELECT_IDLE 1'h1
`define SCLK_IDLE 1'h1
`define CODE_ZERO 12'h000
`define CODE_MID_LOW 12'h7FF
`define CODE_MID 12'h800
`define CODE_FULL 12'hFFF

`endif

// ### tb/analog_model.sv
// Comparator stand-in for the analog section of the converter.
// Assumes a held input level and the trial code of the control block.
`timescale 1ns/1ps
module analog_model (
    input wire [11:0] trial_code,
    input wire [11:0] level,
    output wire comparator
);
    // High while the held input is at or above the trial code
    assign comparator = (trial_code <= level);
endmodule // analog_model

// ### tb/sar_adc_props.sv
// Checker of the converter control block, bound to its ports.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
module sar_adc_props #(
    parameter BITS = 12
) (
    input wire clock,
    input wire rst_n,
    input wire select_n,
    input wire serial_bit_clock,
    input wire data_out,
    input wire data_out_en,
    input wire sample_en,
    input wire analog_on,
    input wire digital_on,
    input wire result_valid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_float; !data_out_en |-> !data_out; endproperty
    a_float: assert property (p_float) else $error("data driven while floating");
    property p_abort; select_n [*8] |=> !data_out_en; endproperty
    a_abort: assert property (p_abort) else $error("output kept after select high");
    property p_down; select_n [*8] |=> !analog_on && !digital_on; endproperty
    a_down: assert property (p_down) else $error("power kept with select high");
    property p_done; result_valid |-> ##[0:2] !analog_on; endproperty
    a_done: assert property (p_done) else $error("analog on after done");
    property p_dig; result_valid && !select_n |-> digital_on; endproperty
    a_dig: assert property (p_dig) else $error("digital off after done");
    property p_pulse; result_valid |=> !result_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("result pulse too long");
    property p_null; $rose(data_out_en) |-> !data_out; endproperty
    a_null: assert property (p_null) else $error("first bit not low");
    property p_smp; sample_en |-> !data_out_en; endproperty
    a_smp: assert property (p_smp) else $error("output on while sampling");
    // Abort may move the line at any phase, so only frames in progress count
    property p_edge; $changed(data_out) && !select_n |-> !serial_bit_clock; endproperty
    a_edge: assert property (p_edge) else $error("bit moved off falling edge");
    c_done: cover property (result_valid);
    c_end: cover property ($fell(data_out_en));
    c_smp: cover property ($rose(sample_en));
    c_short: cover property (data_out_en && select_n);
endmodule // sar_adc_props
bind sar_adc_control sar_adc_props #(.BITS(BITS)) u_props (.clock(clock), .rst_n(rst_n),
    .select_n(select_n), .serial_bit_clock(serial_bit_clock), .data_out(data_out),
    .data_out_en(data_out_en), .sample_en(sample_en), .analog_on(analog_on),
    .digital_on(digital_on), .result_valid(result_valid));

// ### tb/testbench.sv
// Self-checking bench: host drives select and serial clock, compares each bit.
// Assumes the analog_model partner and inputs changed on the falling clock edge.
`timescale 1ns/1ps
module testbench;
    localparam [47:0] CODES = {12'hFFF, 12'h800, 12'h7FF, 12'h000};
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg select_n = 1'b1;
    reg serial_bit_clock = 1'b1;
    reg [11:0] level = 12'h000;
    reg [31:0] seed = 32'h3A2A0FDC;
    integer bad_count = 0;
    integer n_compared = 0;
    integer i;
    wire comparator, data_out, data_out_en, sample_en, analog_on, digital_on, result_valid;
    wire [11:0] trial_code, result;
    initial forever #2.5 clock = ~clock;
    analog_model u_ana (.trial_code(trial_code), .level(level), .comparator(comparator));
    sar_adc_control u_dut (.clock(clock), .rst_n(rst_n), .select_n(select_n),
        .serial_bit_clock(serial_bit_clock), .comparator(comparator), .data_out(data_out),
        .data_out_en(data_out_en), .trial_code(trial_code), .sample_en(sample_en),
        .analog_on(analog_on), .digital_on(digital_on), .result(result),
        .result_valid(result_valid));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected {enable, bit} at each serial clock rise, oldest first
    reg [1:0] expq[$];
    task check(input [12:0] got, input [12:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("mismatch at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    // Slow serial clock: six system clocks per half keeps the sync margin
    task conv(input [11:0] code, input integer n);
        integer k;
        integer b;
        reg [1:0] exp_pair;
        begin
            // Model: null bit, result MSB first, then bits 1 to 11 again
            expq.delete();
            expq.push_back(2'b10);
            for (b = 11; b >= 0; b = b - 1) expq.push_back({1'b1, code[b]});
            for (b = 1; b <= 11; b = b + 1) expq.push_back({1'b1, code[b]});
            level = code;
            select_n = 1'b0;
            repeat (6) @(negedge clock);
            for (k = 1; k <= n; k = k + 1) begin
                serial_bit_clock = 1'b0;
                repeat (6) @(negedge clock);
                serial_bit_clock = 1'b1;
                check(sample_en, k < 2);
                if (k > 1) begin
                    exp_pair = 2'b00;
                    if (expq.size() > 0) exp_pair = expq.pop_front();
                    check({data_out_en, data_out}, exp_pair);
                end
                repeat (6) @(negedge clock);
            end
            if (n > 24) check(result, code);
            if (n > 24) check({analog_on, digital_on}, 2'b01);
            select_n = 1'b1;
            repeat (8) @(negedge clock);
            check(data_out_en, 1'b0);
            check({analog_on, digital_on}, 2'b00);
        end
    endtask
    task give_verdict;
        begin
            if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    // ------------------------------------------------------------
    // Sequence: fixed codes with 27 to 30 clocks each, random, short cycle
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        repeat (8) @(negedge clock);
        for (i = 0; i < 4; i = i + 1) conv(CODES[12 * i +: 12], 27 + i);
        for (i = 0; i < 3; i = i + 1) begin
            seed = lfsr(seed);
            conv(seed[11:0], 27);
        end
        conv(seed[23:12], 10);
        give_verdict;
    end
    initial begin
        #200000;
        bad_count = bad_count + 1;
        give_verdict;
    end
endmodule // testbench
